// ===== button_mode_pkg.sv
// Constants shared by the button reset and mode selector.
package button_mode_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int DEBOUNCE_MS = 20;
   localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int BLINK_PERIOD_MS = 1000;
   localparam int BLINK_PERIOD_CYCLES = CLK_HZ / 1000 * BLINK_PERIOD_MS;
   localparam int RESET_PULSE_US = 10;
   localparam int RESET_PULSE_CYCLES = CLK_HZ / 1_000_000 * RESET_PULSE_US;
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_FACTORY = 2'h1;
   localparam logic [1:0] SEL_RUN_HOLD = 2'h2;
   localparam logic [1:0] SEL_AUTO_ADDR = 2'h3;
   localparam logic [31:0] DEFAULT_ADDR_PORT0 = 32'hc0a8_a464;
   localparam logic [31:0] DEFAULT_ADDR_PORT1 = 32'hc0a8_a564;
endpackage

// ===== button_pair_if.sv
// Interface carrying debounced button levels and the right button's press edge.
`timescale 1ns/1ps
interface button_pair_if;
   logic left_held;
   logic right_held;
   logic right_press;
   modport source (output left_held, right_held, right_press);
   modport sink (input left_held, right_held, right_press);
endinterface

// ===== button_debounce.sv
// Debouncer for both push buttons with a press edge for the right one.
`timescale 1ns/1ps
module button_debounce #(
   parameter int STABLE_CYCLES = button_mode_pkg::DEBOUNCE_CYCLES
) (
   input wire logic clk_sys, // System clock.
   input wire logic reset_n, // Synchronous reset, active low.
   input wire logic left_raw, // Left button, high while pressed.
   input wire logic right_raw, // Right button, high while pressed.
   button_pair_if.source btn // Clean levels and press edge.
);
   initial begin
      if (STABLE_CYCLES < 1) $error("STABLE_CYCLES must be at least 1");
   end
   localparam int CW = $clog2(STABLE_CYCLES + 1);
   typedef struct packed {
      logic [CW-1:0] left_count;
      logic [CW-1:0] right_count;
      logic left;
      logic right;
      logic press;
   } deb_state_t;
   deb_state_t state;
   deb_state_t next_state;

   always_comb begin
      next_state = state;
      next_state.press = 1'b0;
      if (left_raw == state.left) begin
         next_state.left_count = '0;
      end else if (state.left_count == CW'(STABLE_CYCLES - 1)) begin
         next_state.left = left_raw;
         next_state.left_count = '0;
      end else begin
         next_state.left_count = state.left_count + 1'b1;
      end
      if (right_raw == state.right) begin
         next_state.right_count = '0;
      end else if (state.right_count == CW'(STABLE_CYCLES - 1)) begin
         next_state.right = right_raw;
         next_state.right_count = '0;
         next_state.press = right_raw;
      end else begin
         next_state.right_count = state.right_count + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign btn.left_held = state.left;
   assign btn.right_held = state.right;
   assign btn.right_press = state.press;
endmodule

// ===== button_reset_mode_selector.sv
// Two-button reset and mode selector for the controller.
`timescale 1ns/1ps
module button_reset_mode_selector #(
   parameter int DEBOUNCE_CYCLES = button_mode_pkg::DEBOUNCE_CYCLES,
   parameter int BLINK_PERIOD_CYCLES = button_mode_pkg::BLINK_PERIOD_CYCLES,
   parameter int RESET_PULSE_CYCLES = button_mode_pkg::RESET_PULSE_CYCLES
) (
   input wire logic clk_sys, // System clock, 100 MHz.
   input wire logic reset_n, // Synchronous reset, active low.
   input wire logic left_button, // Left button, high while pressed.
   input wire logic right_button, // Right button, high while pressed.
   input wire logic addr_server_present, // An address server answers.
   input wire logic [31:0] server_addr_port0, // Offered address, port 0.
   input wire logic [31:0] server_addr_port1, // Offered address, port 1.
   output logic controller_reset, // Controller reset pulse, high active.
   output logic erase_config, // Erase configuration, with the reset.
   output logic hold_mode, // High in hold, low in run.
   output logic run_indicator, // Run indicator lamp.
   output logic hold_indicator, // Hold indicator lamp.
   output logic select_indicator, // Blinks the selected mode count.
   output logic [31:0] addr_port0, // Address in force on port 0.
   output logic [31:0] addr_port1, // Address in force on port 1.
   output logic addr_from_server // Address came from a server.
);
   initial begin
      if (BLINK_PERIOD_CYCLES < 12) $error("BLINK_PERIOD_CYCLES too small");
      if (RESET_PULSE_CYCLES < 1) $error("RESET_PULSE_CYCLES too small");
   end

   localparam int BW = $clog2(BLINK_PERIOD_CYCLES + 1);
   localparam int PW = $clog2(RESET_PULSE_CYCLES + 1);

   typedef enum {
      ST_IDLE,
      ST_PLAIN,
      ST_SELECT,
      ST_ABANDON,
      ST_RESET
   } sel_phase_t;

   typedef struct packed {
      sel_phase_t phase;
      logic [1:0] selection;
      logic [1:0] action;
      logic [BW-1:0] blink_count;
      logic [PW-1:0] pulse_count;
      logic hold;
      logic from_server;
      logic [31:0] addr0;
      logic [31:0] addr1;
      logic reset_out;
      logic erase_out;
      logic led;
   } sel_state_t;

   sel_state_t state;
   sel_state_t next_state;

   button_pair_if btn ();

   button_debounce #(
      .STABLE_CYCLES(DEBOUNCE_CYCLES)
   ) u_debounce (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .left_raw(left_button),
      .right_raw(right_button),
      .btn(btn)
   );

   // --------------------------------------------------------------
   // Blink pattern
   // --------------------------------------------------------------

   // Lamp on in the first half of each of n equal slices of a second.
   function automatic logic blink_on(input logic [BW-1:0] count,
                                     input logic [1:0] n);
      logic [BW+1:0] scaled;
      logic [BW+1:0] slice;
      scaled = (BW+2)'(count) * (BW+2)'(n);
      slice = (BW+2)'(BLINK_PERIOD_CYCLES);
      while (scaled >= slice && slice != '0) begin
         scaled = scaled - slice;
      end
      return (n != 2'h0) && (scaled < (slice >> 1));
   endfunction

   // --------------------------------------------------------------
   // Selection and reset sequencing
   // --------------------------------------------------------------

   always_comb begin
      next_state = state;
      next_state.reset_out = 1'b0;
      next_state.erase_out = 1'b0;
      if (state.blink_count == BW'(BLINK_PERIOD_CYCLES - 1)) begin
         next_state.blink_count = '0;
      end else begin
         next_state.blink_count = state.blink_count + 1'b1;
      end
      case (state.phase)
         ST_IDLE: begin
            next_state.selection = button_mode_pkg::SEL_NONE;
            if (btn.left_held) begin
               next_state.phase = ST_SELECT;
               next_state.blink_count = '0;
               // A click that settles together with the left button counts.
               if (btn.right_press) begin
                  next_state.selection = button_mode_pkg::SEL_FACTORY;
               end
            end else if (btn.right_press) begin
               next_state.phase = ST_PLAIN;
            end
         end
         ST_PLAIN: begin
            if (btn.left_held) begin
               next_state.phase = ST_SELECT;
               next_state.blink_count = '0;
            end else if (!btn.right_held) begin
               next_state.action = button_mode_pkg::SEL_NONE;
               next_state.phase = ST_RESET;
               next_state.pulse_count = '0;
            end
         end
         ST_SELECT: begin
            if (btn.right_press) begin
               if (state.selection == button_mode_pkg::SEL_AUTO_ADDR) begin
                  next_state.selection = button_mode_pkg::SEL_FACTORY;
               end else begin
                  next_state.selection = state.selection + 2'h1;
               end
               next_state.blink_count = '0;
            end
            if (!btn.left_held) begin
               if (btn.right_held) begin
                  next_state.phase = ST_ABANDON;
               end else if (state.selection == button_mode_pkg::SEL_NONE) begin
                  next_state.phase = ST_IDLE;
               end else begin
                  next_state.action = state.selection;
                  next_state.phase = ST_RESET;
                  next_state.pulse_count = '0;
               end
            end
         end
         ST_ABANDON: begin
            next_state.selection = button_mode_pkg::SEL_NONE;
            if (!btn.right_held) begin
               next_state.phase = ST_IDLE;
            end
         end
         ST_RESET: begin
            next_state.reset_out = 1'b1;
            next_state.erase_out =
               (state.action == button_mode_pkg::SEL_FACTORY);
            if (state.pulse_count == PW'(RESET_PULSE_CYCLES)) begin
               next_state.phase = ST_IDLE;
               next_state.reset_out = 1'b0;
               next_state.erase_out = 1'b0;
               if (state.action == button_mode_pkg::SEL_RUN_HOLD) begin
                  next_state.hold = !state.hold;
               end
               if (addr_server_present) begin
                  next_state.from_server = 1'b1;
                  next_state.addr0 = server_addr_port0;
                  next_state.addr1 = server_addr_port1;
               end else if (state.action ==
                            button_mode_pkg::SEL_AUTO_ADDR) begin
                  next_state.from_server = 1'b0;
                  next_state.addr0 = button_mode_pkg::DEFAULT_ADDR_PORT0;
                  next_state.addr1 = button_mode_pkg::DEFAULT_ADDR_PORT1;
               end else begin
                  next_state.from_server = 1'b0;
               end
            end else begin
               next_state.pulse_count = state.pulse_count + 1'b1;
            end
         end
         default: begin
            next_state.phase = ST_IDLE;
         end
      endcase
      next_state.led = (state.phase == ST_SELECT) &&
                       blink_on(state.blink_count, state.selection);
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= '0;
         state.phase <= ST_IDLE;
         state.addr0 <= button_mode_pkg::DEFAULT_ADDR_PORT0;
         state.addr1 <= button_mode_pkg::DEFAULT_ADDR_PORT1;
      end else begin
         state <= next_state;
      end
   end

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------

   assign controller_reset = state.reset_out;
   assign erase_config = state.erase_out;
   assign hold_mode = state.hold;
   assign hold_indicator = state.hold && !state.reset_out;
   assign run_indicator = !state.hold && !state.reset_out;
   assign select_indicator = state.led;
   assign addr_port0 = state.addr0;
   assign addr_port1 = state.addr1;
   assign addr_from_server = state.from_server;
endmodule

// ===== button_reset_mode_selector_chk.sv
// Checker of pulse, lamp and address relations at the selector's ports.
`timescale 1ns/1ps
module button_reset_mode_selector_chk #(
   parameter int RESET_PULSE_CYCLES = 3
) (
   input wire logic clk_sys, // System clock.
   input wire logic reset_n, // Reset, active low.
   input wire logic left_button, // Left button.
   input wire logic right_button, // Right button.
   input wire logic addr_server_present, // Server answers.
   input wire logic [31:0] server_addr_port0, // Offer, port 0.
   input wire logic controller_reset, // Reset pulse.
   input wire logic erase_config, // Erase strobe.
   input wire logic hold_mode, // Hold level.
   input wire logic run_indicator, // Run lamp.
   input wire logic hold_indicator, // Hold lamp.
   input wire logic [31:0] addr_port0, // Address, port 0.
   input wire logic addr_from_server // Server flag.
);
   logic [15:0] high_cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !controller_reset) high_cnt <= 16'h0000;
      else high_cnt <= high_cnt + 16'h0001;
   end
   property p_pulse_len;
      $fell(controller_reset) |-> high_cnt == 16'(RESET_PULSE_CYCLES);
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset pulse length wrong");
   property p_erase_in;
      erase_config |-> controller_reset;
   endproperty
   a_erase_in: assert property (p_erase_in)
      else $error("erase outside reset pulse");
   property p_erase_start;
      $rose(erase_config) |-> $rose(controller_reset);
   endproperty
   a_erase_start: assert property (p_erase_start)
      else $error("erase started inside pulse");
   property p_lamps_dark;
      controller_reset |-> !run_indicator && !hold_indicator;
   endproperty
   a_lamps_dark: assert property (p_lamps_dark)
      else $error("lamps lit during reset");
   property p_lamps_mode;
      !controller_reset && !$past(controller_reset) |->
         hold_indicator == hold_mode && run_indicator == !hold_mode;
   endproperty
   a_lamps_mode: assert property (p_lamps_mode)
      else $error("lamps disagree with mode");
   property p_hold_moves;
      $changed(hold_mode) |-> $past(controller_reset);
   endproperty
   a_hold_moves: assert property (p_hold_moves)
      else $error("mode changed outside reset");
   property p_addr_moves;
      $changed(addr_port0) |-> $past(controller_reset);
   endproperty
   a_addr_moves: assert property (p_addr_moves)
      else $error("address changed outside reset");
   property p_server;
      $fell(controller_reset) && $past(addr_server_present) |->
         addr_from_server && addr_port0 == $past(server_addr_port0);
   endproperty
   a_server: assert property (p_server)
      else $error("server address not taken");
   property p_start_clean;
      $rose(controller_reset) |-> !$past(left_button) &&
         !$past(right_button) && !$past(left_button, 4) &&
         !$past(right_button, 4);
   endproperty
   a_start_clean: assert property (p_start_clean)
      else $error("reset started with a button down");
   c_erase: cover property ($rose(erase_config));
   c_hold: cover property ($fell(hold_mode));
   c_server: cover property ($rose(addr_from_server));
endmodule
bind button_reset_mode_selector button_reset_mode_selector_chk #(
   .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) u_chk (.clk_sys(clk_sys),
   .reset_n(reset_n), .left_button(left_button), .hold_mode(hold_mode),
   .right_button(right_button), .addr_server_present(addr_server_present),
   .server_addr_port0(server_addr_port0), .erase_config(erase_config),
   .controller_reset(controller_reset), .run_indicator(run_indicator),
   .hold_indicator(hold_indicator), .addr_port0(addr_port0),
   .addr_from_server(addr_from_server));

// ===== button_operator.sv
// Operator model pressing the two push buttons.
`timescale 1ns/1ps
module button_operator (
   input wire logic clk_sys, // System clock.
   output logic left_button, // Left button, high pressed.
   output logic right_button // Right button, high pressed.
);
   initial begin
      left_button = 1'b0;
      right_button = 1'b0;
   end
   // Sets both buttons, then keeps them for n cycles.
   task automatic act(input logic l, input logic r, input int n);
      @(posedge clk_sys);
      left_button <= l;
      right_button <= r;
      repeat (n) @(posedge clk_sys);
   endtask
   // Clicks the right button n times with the left one kept at l.
   task automatic clicks(input logic l, input int n);
      for (int i = 0; i < n; i++) begin
         act(l, 1'b1, 8);
         act(l, 1'b0, 8);
      end
   endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the button reset and mode selector.
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic lf; int n; logic srv; logic er; logic hd; logic own;}
      row_t;
   localparam logic [31:0] S0 = 32'h0a0b_0c0d;
   localparam logic [31:0] S1 = 32'h0a0b_0c0e;
   row_t rows[7] = '{'{0, 1, 1, 0, 0, 1}, '{1, 1, 0, 1, 0, 1},
      '{1, 2, 0, 0, 1, 1}, '{1, 2, 0, 0, 0, 1}, '{1, 3, 0, 0, 0, 0},
      '{1, 4, 0, 1, 0, 0}, '{1, 3, 1, 0, 0, 1}};
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic left_button, right_button, srv_on = 1'b0;
   logic controller_reset, erase_config, hold_mode, run_indicator;
   logic hold_indicator, select_indicator, addr_from_server, prev;
   logic got_pulse = 1'b0;
   logic got_erase = 1'b0;
   logic [31:0] addr_port0, addr_port1;
   int error_cnt = 0;
   int comparisons = 0;
   int rises;
   always #5 clk_sys = ~clk_sys;
   button_operator u_button_operator (.clk_sys(clk_sys),
      .left_button(left_button), .right_button(right_button));
   button_reset_mode_selector #(.DEBOUNCE_CYCLES(4), .BLINK_PERIOD_CYCLES(60),
      .RESET_PULSE_CYCLES(3)) u_button_reset_mode_selector (.clk_sys(clk_sys),
      .reset_n(reset_n), .left_button(left_button), .hold_mode(hold_mode),
      .right_button(right_button), .addr_server_present(srv_on),
      .server_addr_port0(S0), .server_addr_port1(S1),
      .controller_reset(controller_reset), .erase_config(erase_config),
      .run_indicator(run_indicator), .hold_indicator(hold_indicator),
      .select_indicator(select_indicator), .addr_port0(addr_port0),
      .addr_port1(addr_port1), .addr_from_server(addr_from_server));
   always @(negedge clk_sys) begin
      if (controller_reset === 1'b1) begin
         got_pulse = 1'b1;
         got_erase = erase_config;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Waits until a pulse has come and gone, or a quiet spell has passed.
   task automatic settle();
      for (int k = 0; k < 80; k++) begin
         @(negedge clk_sys);
         if (got_pulse && controller_reset === 1'b0) break;
      end
   endtask
   task automatic do_reset();
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      chk({controller_reset, hold_mode, run_indicator, select_indicator},
         4'h2);
      chk(addr_port0, button_mode_pkg::DEFAULT_ADDR_PORT0);
      chk(addr_port1, button_mode_pkg::DEFAULT_ADDR_PORT1);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      results();
   end
   initial begin
      do_reset();
      foreach (rows[i]) begin
         @(posedge clk_sys);
         srv_on <= rows[i].srv;
         got_pulse = 1'b0;
         u_button_operator.act(rows[i].lf, 1'b0, 8);
         u_button_operator.clicks(rows[i].lf, rows[i].n);
         if (rows[i].lf) begin
            @(negedge clk_sys);
            prev = select_indicator;
            rises = 0;
            repeat (60) begin
               @(negedge clk_sys);
               rises += int'(select_indicator === 1'b1 && prev === 1'b0);
               prev = select_indicator;
            end
            chk(rises, (rows[i].n - 1) % 3 + 1);
         end
         u_button_operator.act(1'b0, 1'b0, 0);
         settle();
         chk({got_pulse, got_erase}, {1'b1, rows[i].er});
         chk(hold_mode, rows[i].hd);
         chk(addr_port0, rows[i].own ? S0 : 32'hc0a8_a464);
         chk(addr_port1, rows[i].own ? S1 : 32'hc0a8_a564);
         chk(addr_from_server, rows[i].srv);
         chk({hold_indicator, run_indicator}, rows[i].hd ? 2 : 1);
      end
      got_pulse = 1'b0;
      u_button_operator.clicks(1'b1, 1);
      u_button_operator.act(1'b1, 1'b1, 8);
      u_button_operator.act(1'b0, 1'b1, 8);
      u_button_operator.act(1'b0, 1'b0, 8);
      settle();
      chk(got_pulse, 1'b0);
      u_button_operator.act(1'b1, 1'b0, 8);
      u_button_operator.act(1'b0, 1'b0, 8);
      u_button_operator.act(1'b0, 1'b1, 1);
      u_button_operator.act(1'b0, 1'b0, 8);
      settle();
      chk(got_pulse, 1'b0);
      u_button_operator.clicks(1'b1, 2);
      u_button_operator.act(1'b0, 1'b0, 0);
      settle();
      chk({got_pulse, hold_mode}, 2'h3);
      do_reset();
      results();
   end
endmodule
